//--- rtl/hwa_alarm_top.sv
/*
  Alarm and interrupt logic of a hardware-monitor unit: shared management-interrupt /
  over-temperature pin, chassis-intrusion latch, tone alarm and the index/data port pair.
  Assumes io requests, temperature readings and alarm inputs come from clk_sys logic;
  only the intrusion pin is asynchronous.
*/
module hwa_alarm_top
  import hwa_pkg::*;
#(
  parameter int LO_HALF_CYC = TONE_LO_HALF_CYC,
  parameter int HI_HALF_CYC = TONE_HI_HALF_CYC,
  parameter int PHASE_CYC   = TONE_PHASE_CYC
) (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                resetn,
  // host i/o and configuration
  input  wire hwa_io_req_t         io_req,
  input  wire hwa_cfg_t            cfg,
  output logic [7:0]               io_rdata,
  // monitored values
  input  wire hwa_temp_t           temp,
  input  wire logic [NUM_VOLT-1:0] volt_alarm,
  input  wire logic [NUM_FAN-1:0]  fan_alarm,
  input  wire logic                case_open_n,
  // pins
  output logic                     alarm_pin_n,
  output logic                     tone_alarm_out,
  output logic                     tone_alarm_oe
);
  // port decode, used for both ports
  function automatic logic port_hit(input logic [15:0] addr, input hwa_cfg_t c, input logic [15:0] ofs);
    port_hit = addr == ({c.base_addr_high_cfg, c.base_addr_low_cfg} + ofs);
  endfunction

  logic                     idx_hit, data_hit;
  logic [PTR_W-1:0]         ptr_q, ptr_d;
  logic [BANK_W-1:0]        bank_q, bank_d;
  logic [7:0]               ovt_cfg_q, ovt_cfg_d, tmode_q, tmode_d;
  logic [1:0]               ovt_mode_q, ovt_mode_d;   // banks 1 and 2
  logic                     intr_clr_q, intr_clr_d;
  logic [7:0]               en0_q, en0_d, en1_q, en1_d, user_q, user_d;
  logic [NUM_SENS-1:0][7:0] over_q, over_d, hyst_q, hyst_d;
  logic [7:0]               rdata_q, rdata_d, rd_val;
  logic                     sts_rd, lim_sel;
  logic [1:0]               sidx;

  assign idx_hit  = port_hit(io_req.addr, cfg, IDX_PORT_OFS);
  assign data_hit = port_hit(io_req.addr, cfg, DATA_PORT_OFS);
  assign lim_sel  = bank_q < BANK_W'(NUM_SENS);
  assign sidx     = bank_q[1:0];

  // sensor, intrusion and status state
  logic [NUM_SENS-1:0]     above_q, above_d, over_now, under_now, rise, fall, ovt_en, ovt_int;
  logic [NUM_SENS-1:0]     smi_ev_all, ovt_ev, ovt_cmp;
  logic [4:0]              sts_q, sts_d;
  logic                    sync1_q, sync2_q, prev_q, latch_q, latch_d, clr_prev_q, clr_src, clr_now;

  // read mux of the data port
  always_comb begin
    rd_val = REG_RST;
    if (ptr_q == IDX_BANK) begin
      rd_val = {5'h00, bank_q};
    end else if (lim_sel && ptr_q == IDX_LIM_OVER) begin
      rd_val = over_q[sidx];
    end else if (lim_sel && ptr_q == IDX_LIM_HYST) begin
      rd_val = hyst_q[sidx];
    end else begin
      case ({bank_q, ptr_q})
        {BANK0, IDX_OVT_CFG}:   rd_val = ovt_cfg_q;
        {BANK0, IDX_TEMP_MODE}: rd_val = tmode_q;
        {BANK1, IDX_OVT_MODE}:  rd_val = {6'h00, ovt_mode_q[0], 1'b0};
        {BANK2, IDX_OVT_MODE}:  rd_val = {6'h00, ovt_mode_q[1], 1'b0};
        {BANK0, IDX_TONE_EN0}:  rd_val = en0_q;
        {BANK0, IDX_TONE_EN1}:  rd_val = en1_q;
        {BANK4, IDX_USER_TONE}: rd_val = user_q;
        {BANK0, IDX_STATUS}:    rd_val = {3'h0, sts_q};
        {BANK0, IDX_INTRUSION}: rd_val = {intr_clr_q, latch_q, sync2_q, 5'h00};
        default:                rd_val = REG_RST;
      endcase
    end
  end

  // register file next state
  always_comb begin
    ptr_d      = ptr_q;
    bank_d     = bank_q;
    ovt_cfg_d  = ovt_cfg_q;
    tmode_d    = tmode_q;
    ovt_mode_d = ovt_mode_q;
    intr_clr_d = intr_clr_q;
    en0_d      = en0_q;
    en1_d      = en1_q;
    user_d     = user_q;
    over_d     = over_q;
    hyst_d     = hyst_q;
    rdata_d    = rdata_q;
    sts_rd     = 1'b0;
    if (io_req.rd && idx_hit) begin
      rdata_d = {1'b0, ptr_q};
    end
    if (io_req.wr && idx_hit) begin
      ptr_d = io_req.wdata[PTR_W-1:0];
    end
    if (io_req.rd && data_hit) begin
      rdata_d = rd_val;
      sts_rd  = bank_q == BANK0 && ptr_q == IDX_STATUS;
    end
    if (io_req.wr && data_hit) begin
      if (ptr_q == IDX_BANK) begin
        bank_d = io_req.wdata[BANK_W-1:0];
      end else if (lim_sel && ptr_q == IDX_LIM_OVER) begin
        over_d[sidx] = io_req.wdata;
      end else if (lim_sel && ptr_q == IDX_LIM_HYST) begin
        hyst_d[sidx] = io_req.wdata;
      end else begin
        case ({bank_q, ptr_q})
          {BANK0, IDX_OVT_CFG}:   ovt_cfg_d = io_req.wdata;
          {BANK0, IDX_TEMP_MODE}: tmode_d = io_req.wdata;
          {BANK1, IDX_OVT_MODE}:  ovt_mode_d[0] = io_req.wdata[BIT_OVT_INT];
          {BANK2, IDX_OVT_MODE}:  ovt_mode_d[1] = io_req.wdata[BIT_OVT_INT];
          {BANK0, IDX_TONE_EN0}:  en0_d = io_req.wdata;
          {BANK0, IDX_TONE_EN1}:  en1_d = io_req.wdata;
          {BANK4, IDX_USER_TONE}: user_d = io_req.wdata;
          {BANK0, IDX_INTRUSION}: intr_clr_d = io_req.wdata[BIT_INTR_CLR];
          default:                ;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ptr_q      <= IDX_PORT_RST[PTR_W-1:0];
      bank_q     <= BANK0;
      ovt_cfg_q  <= REG_RST;
      tmode_q    <= REG_RST;
      ovt_mode_q <= '0;
      intr_clr_q <= 1'b0;
      en0_q      <= REG_RST;
      en1_q      <= REG_RST;
      user_q     <= REG_RST;
      over_q     <= {NUM_SENS{LIM_OVER_RST}};
      hyst_q     <= {NUM_SENS{LIM_HYST_RST}};
      rdata_q    <= REG_RST;
    end else begin
      ptr_q      <= ptr_d;
      bank_q     <= bank_d;
      ovt_cfg_q  <= ovt_cfg_d;
      tmode_q    <= tmode_d;
      ovt_mode_q <= ovt_mode_d;
      intr_clr_q <= intr_clr_d;
      en0_q      <= en0_d;
      en1_q      <= en1_d;
      user_q     <= user_d;
      over_q     <= over_d;
      hyst_q     <= hyst_d;
      rdata_q    <= rdata_d;
    end
  end

  // per-sensor enables and over-temp modes, sys/cpu/aux
  assign ovt_en  = {tmode_q[BIT_AUX_OVT_EN], tmode_q[BIT_CPU_OVT_EN], ovt_cfg_q[BIT_SYS_OVT_EN]};
  assign ovt_int = {ovt_mode_q[1], ovt_mode_q[0], ovt_cfg_q[BIT_SYS_OVT_INT]};

  // threshold crossings, evaluated only when a reading arrives
  for (genvar s = 0; s < NUM_SENS; s++) begin : g_sens
    assign over_now[s]  = temp.valid[s] && $signed(temp.value[s]) > $signed(over_q[s]);
    assign under_now[s] = temp.valid[s] && $signed(temp.value[s]) < $signed(hyst_q[s]);
    assign above_d[s]   = over_now[s] | (above_q[s] & ~under_now[s]);
    assign rise[s]      = over_now[s] & ~above_q[s];
    assign fall[s]      = under_now[s] & above_q[s];
    // comparator re-raises on every reading above; two-times only on the edges
    assign smi_ev_all[s] = tmode_q[BIT_CMP_MODE] ? temp.valid[s] & above_d[s]
                                                 : rise[s] | fall[s];
    assign ovt_ev[s]     = ovt_en[s] & ovt_int[s] & (rise[s] | fall[s]);
    assign ovt_cmp[s]    = ovt_en[s] & ~ovt_int[s] & above_q[s];
  end

  // status: events set, a status read clears, set wins over clear
  always_comb begin
    sts_d = sts_rd ? 5'h00 : sts_q;
    sts_d[STS_SMI_LSB +: 2] = sts_d[STS_SMI_LSB +: 2] | smi_ev_all[2:1];
    sts_d[STS_OVT_LSB +: 3] = sts_d[STS_OVT_LSB +: 3] | ovt_ev;
  end

  // intrusion: falling edge latched, cleared by a one then zero on either source
  always_comb begin
    clr_src = intr_clr_q | cfg.intrusion_clear_cfg[BIT_CFG_CLR];
    clr_now = clr_prev_q & ~clr_src;
    latch_d = (prev_q & ~sync2_q) | (latch_q & ~clr_now);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      above_q    <= '0;
      sts_q      <= 5'h00;
      sync1_q    <= 1'b1;
      sync2_q    <= 1'b1;
      prev_q     <= 1'b1;
      latch_q    <= 1'b0;
      clr_prev_q <= 1'b0;
    end else begin
      above_q    <= above_d;
      sts_q      <= sts_d;
      sync1_q    <= case_open_n;
      sync2_q    <= sync1_q;
      prev_q     <= sync2_q;
      latch_q    <= latch_d;
      clr_prev_q <= clr_src;
    end
  end

  // shared pin and tone request
  logic                       pin_n_q, pin_n_d, tone_req_q, tone_req_d;
  logic [NUM_VOLT+NUM_FAN+NUM_SENS-1:0] ev_vec, ev_en;

  always_comb begin
    // pending management interrupt holds the pin until status is read
    pin_n_d = cfg.alarm_pin_function_cfg[BIT_ALARM_SMI]
            ? ~(|sts_q[STS_SMI_LSB +: 2])
            : ~((|ovt_cmp) | (|sts_q[STS_OVT_LSB +: 3]));
    ev_vec = {fan_alarm, above_q, volt_alarm};
    ev_en  = {user_q[1:0], en1_q[6:0], en0_q};
    tone_req_d = en1_q[BIT_TONE_GLOBAL]
               & ((|(ev_vec & ev_en)) | ~sync2_q | user_q[BIT_USER_TONE]);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pin_n_q    <= 1'b1;
      tone_req_q <= 1'b0;
    end else begin
      pin_n_q    <= pin_n_d;
      tone_req_q <= tone_req_d;
    end
  end

  hwa_tone_gen #(
    .LO_HALF_CYC (LO_HALF_CYC),
    .HI_HALF_CYC (HI_HALF_CYC),
    .PHASE_CYC   (PHASE_CYC)
  ) u_tone (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .active   (tone_req_q),
    .pin_sel  (~cfg.tone_pin_function_cfg[BIT_TONE_PIN]),
    .tone_out (tone_alarm_out),
    .tone_oe  (tone_alarm_oe)
  );

  assign io_rdata    = rdata_q;
  assign alarm_pin_n = pin_n_q;
endmodule

//--- rtl/hwa_tone_gen.sv
/*
  Two-tone alarm generator driving an open-drain pin.
  Assumes active is a same-clock level; the pin is pulled up outside.
*/
module hwa_tone_gen
  import hwa_pkg::*;
#(
  parameter int LO_HALF_CYC = TONE_LO_HALF_CYC,
  parameter int HI_HALF_CYC = TONE_HI_HALF_CYC,
  parameter int PHASE_CYC   = TONE_PHASE_CYC
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic resetn,
  // control
  input  wire logic active,
  input  wire logic pin_sel,
  // open-drain pin
  output logic      tone_out,
  output logic      tone_oe
);
  localparam int PW = $clog2(PHASE_CYC + 1);
  localparam int HW = $clog2(LO_HALF_CYC + HI_HALF_CYC + 1);

  logic [PW-1:0] phase_q, phase_d;
  logic [HW-1:0] half_q, half_d;
  logic          hi_q, hi_d, wave_q, wave_d, oe_q, oe_d;
  logic [HW-1:0] half_end;

  // next state: counters run only while the alarm is active
  always_comb begin
    half_end = hi_q ? HW'(HI_HALF_CYC - 1) : HW'(LO_HALF_CYC - 1);
    phase_d  = phase_q + PW'(1);
    half_d   = half_q + HW'(1);
    hi_d     = hi_q;
    wave_d   = wave_q;
    if (!active) begin
      phase_d = '0;
      half_d  = '0;
      hi_d    = 1'b0;
      wave_d  = 1'b0;
    end else begin
      if (phase_q == PW'(PHASE_CYC - 1)) begin
        phase_d = '0;
        hi_d    = ~hi_q;
        half_d  = '0;
      end else if (half_q == half_end) begin
        half_d = '0;
        wave_d = ~wave_q;
      end
    end
    // while pin_sel is set, drive low by default and release only in the high half of a wave; with pin_sel clear, always release
    oe_d = pin_sel & ~(active & wave_q);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      phase_q <= '0;
      half_q  <= '0;
      hi_q    <= 1'b0;
      wave_q  <= 1'b0;
      oe_q    <= 1'b0;
    end else begin
      phase_q <= phase_d;
      half_q  <= half_d;
      hi_q    <= hi_d;
      wave_q  <= wave_d;
      oe_q    <= oe_d;
    end
  end

  assign tone_out = 1'b0; // open drain only ever pulls low
  assign tone_oe  = oe_q;
endmodule

//--- shared/hwa_pkg.sv
/*
  Constants, field positions and carrier types for the hardware-monitor alarm block.
  Assumes a single 250 MHz system clock and 8-bit registers behind an index/data port pair.
*/
package hwa_pkg;
  // sensor and event counts
  localparam int NUM_SENS = 3;
  localparam int NUM_VOLT = 9;
  localparam int NUM_FAN  = 5;
  localparam int PTR_W    = 7;
  localparam int BANK_W   = 3;

  // port offsets from the base address
  localparam logic [15:0] IDX_PORT_OFS  = 16'h0005;
  localparam logic [15:0] DATA_PORT_OFS = 16'h0006;
  localparam logic [7:0]  IDX_PORT_RST  = 8'h00;

  // banks and indexes
  localparam logic [BANK_W-1:0] BANK0 = 3'h0;
  localparam logic [BANK_W-1:0] BANK1 = 3'h1;
  localparam logic [BANK_W-1:0] BANK2 = 3'h2;
  localparam logic [BANK_W-1:0] BANK4 = 3'h4;
  localparam logic [PTR_W-1:0] IDX_OVT_CFG   = 7'h18;
  localparam logic [PTR_W-1:0] IDX_TEMP_MODE = 7'h4c;
  localparam logic [PTR_W-1:0] IDX_OVT_MODE  = 7'h52;
  localparam logic [PTR_W-1:0] IDX_INTRUSION = 7'h46;
  localparam logic [PTR_W-1:0] IDX_TONE_EN0  = 7'h56;
  localparam logic [PTR_W-1:0] IDX_TONE_EN1  = 7'h57;
  localparam logic [PTR_W-1:0] IDX_USER_TONE = 7'h53;
  localparam logic [PTR_W-1:0] IDX_BANK      = 7'h7e;
  localparam logic [PTR_W-1:0] IDX_STATUS    = 7'h41;
  localparam logic [PTR_W-1:0] IDX_LIM_OVER  = 7'h39;
  localparam logic [PTR_W-1:0] IDX_LIM_HYST  = 7'h3a;

  // bit positions
  localparam int BIT_CMP_MODE    = 6;  // temp mode reg
  localparam int BIT_CPU_OVT_EN  = 3;
  localparam int BIT_AUX_OVT_EN  = 4;
  localparam int BIT_SYS_OVT_EN  = 6;  // ovt cfg reg
  localparam int BIT_SYS_OVT_INT = 4;
  localparam int BIT_OVT_INT     = 1;  // banked ovt mode reg
  localparam int BIT_INTR_CLR    = 7;  // intrusion reg
  localparam int BIT_INTR_LATCH  = 6;
  localparam int BIT_INTR_LIVE   = 5;
  localparam int BIT_TONE_GLOBAL = 7;
  localparam int BIT_USER_TONE   = 5;
  localparam int BIT_ALARM_SMI   = 6;  // alarm pin function cfg
  localparam int BIT_TONE_PIN    = 1;  // tone pin function cfg
  localparam int BIT_CFG_CLR     = 5;  // intrusion clear cfg
  localparam int STS_SMI_LSB     = 0;  // status: [1:0] smi cpu/aux
  localparam int STS_OVT_LSB     = 2;  // status: [4:2] ovt sys/cpu/aux

  // reset values
  localparam logic [7:0] REG_RST      = 8'h00;
  localparam logic [7:0] LIM_OVER_RST = 8'h50;
  localparam logic [7:0] LIM_HYST_RST = 8'h4b;

  // tone timing
  localparam longint CLK_HZ        = 250_000_000;
  localparam longint TONE_LO_HZ    = 600;
  localparam longint TONE_HI_HZ    = 1200;
  localparam longint TONE_PHASE_MS = 500;
  localparam int TONE_LO_HALF_CYC = int'(CLK_HZ / (2 * TONE_LO_HZ));
  localparam int TONE_HI_HALF_CYC = int'(CLK_HZ / (2 * TONE_HI_HZ));
  localparam int TONE_PHASE_CYC   = int'(CLK_HZ * TONE_PHASE_MS / 1000);

  // host i/o request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } hwa_io_req_t;

  // configuration bytes of the monitor device
  typedef struct packed {
    logic [7:0] base_addr_high_cfg;
    logic [7:0] base_addr_low_cfg;
    logic [7:0] alarm_pin_function_cfg;
    logic [7:0] tone_pin_function_cfg;
    logic [7:0] intrusion_clear_cfg;
  } hwa_cfg_t;

  // temperature readings, one strobe per sensor (sys, cpu, aux)
  typedef struct packed {
    logic [NUM_SENS-1:0]      valid;
    logic [NUM_SENS-1:0][7:0] value;
  } hwa_temp_t;
endpackage

//--- tb/hwa_alarm_props.sv
/*
  Port-level checks for the hardware-monitor alarm block.
  Assumes it is bound into hwa_alarm_top; one clock, async active-low reset.
*/
module hwa_alarm_props
  import hwa_pkg::*;
#(
  parameter int LO_HALF_CYC = 10,
  parameter int HI_HALF_CYC = 5,
  parameter int PHASE_CYC   = 200
) (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                resetn,
  // host side
  input  wire hwa_io_req_t         io_req,
  input  wire hwa_cfg_t            cfg,
  input  wire logic [7:0]          io_rdata,
  // monitored values
  input  wire hwa_temp_t           temp,
  input  wire logic [NUM_VOLT-1:0] volt_alarm,
  input  wire logic [NUM_FAN-1:0]  fan_alarm,
  input  wire logic                case_open_n,
  // pins
  input  wire logic                alarm_pin_n,
  input  wire logic                tone_alarm_out,
  input  wire logic                tone_alarm_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic [15:0] base;
  logic        idx_hit;
  logic        port_hit;
  logic        cause;
  hwa_cfg_t    cfg_q;
  logic [1:0]  quiet_q;
  logic [1:0]  quiet_d;
  // port decode as the host sees it
  assign base     = {cfg.base_addr_high_cfg, cfg.base_addr_low_cfg};
  assign idx_hit  = io_req.addr == base + IDX_PORT_OFS;
  assign port_hit = idx_hit || io_req.addr == base + DATA_PORT_OFS;
  // cycles since anything that may move the shared pin, saturating
  always_comb begin
    cause   = |temp.valid || io_req.rd || io_req.wr || cfg != cfg_q;
    quiet_d = cause ? 2'h0 : (quiet_q == 2'h3 ? quiet_q : quiet_q + 2'h1);
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cfg_q   <= '0;
      quiet_q <= 2'h0;
    end else begin
      cfg_q   <= cfg;
      quiet_q <= quiet_d;
    end
  end
  property p_reset_out;
    $rose(resetn) |-> alarm_pin_n && io_rdata == 8'h00 && !tone_alarm_oe
      ##1 tone_alarm_oe == !cfg.tone_pin_function_cfg[BIT_TONE_PIN];
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs wrong after reset");
  property p_tone_data;
    tone_alarm_out == 1'b0;
  endproperty
  a_tone_data: assert property (p_tone_data) else $error("tone data not low");
  property p_tone_release;
    cfg.tone_pin_function_cfg[BIT_TONE_PIN] && $past(cfg.tone_pin_function_cfg[BIT_TONE_PIN])
      && $past(cfg.tone_pin_function_cfg[BIT_TONE_PIN], 2) |-> !tone_alarm_oe;
  endproperty
  a_tone_release: assert property (p_tone_release) else $error("tone pin driven while not owned");
  property p_rdata_hold;
    !(io_req.rd && port_hit) |=> $stable(io_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");
  property p_idx_msb;
    io_req.rd && idx_hit |=> !io_rdata[7];
  endproperty
  a_idx_msb: assert property (p_idx_msb) else $error("index bit 7 not zero");
  property p_idx_echo;
    io_req.wr && !io_req.rd && idx_hit ##1 io_req.rd && !io_req.wr && idx_hit
      |=> io_rdata == {1'b0, $past(io_req.wdata[6:0], 2)};
  endproperty
  a_idx_echo: assert property (p_idx_echo) else $error("index readback wrong");
  property p_idx_repeat;
    io_req.rd && !io_req.wr && idx_hit ##1 io_req.rd && !io_req.wr && idx_hit |=> $stable(io_rdata);
  endproperty
  a_idx_repeat: assert property (p_idx_repeat) else $error("index read not repeatable");
  property p_pin_caused;
    $changed(alarm_pin_n) |-> quiet_q != 2'h3;
  endproperty
  a_pin_caused: assert property (p_pin_caused) else $error("alarm pin moved without cause");
  // main scenarios reached
  c_pin_low: cover property ($fell(alarm_pin_n));
  c_tone_toggle: cover property ($fell(tone_alarm_oe) ##[1:20] $rose(tone_alarm_oe));
  c_echo: cover property (io_req.wr && idx_hit ##1 io_req.rd && idx_hit);
endmodule

//--- tb/hwa_alarm_tb_top.sv
/*
  Self-checking bench for the alarm block: ports, interrupt modes, intrusion, tone.
  Assumes shortened tone counts; reads are checked from a queue by a monitor.
*/
module hwa_alarm_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import hwa_pkg::*;
  localparam int LO = 10;
  localparam int HI = 5;
  localparam int PH = 200;
  logic                clk_sys     = 1'b0;
  logic                resetn      = 1'b0;
  hwa_io_req_t         io_req      = '0;
  hwa_cfg_t            cfg;
  hwa_temp_t           temp        = '0;
  logic [NUM_VOLT-1:0] volt_alarm  = '0;
  logic [NUM_FAN-1:0]  fan_alarm   = '0;
  logic                case_open_n = 1'b1;
  logic [7:0]          io_rdata;
  logic                alarm_pin_n;
  logic                tone_alarm_out;
  logic                tone_alarm_oe;
  logic [7:0]          exp_q[$];
  logic [15:0]         base;
  logic [31:0]         seed        = 32'h6ebed5d7;
  logic                took_q      = 1'b0;
  logic [7:0]          n;
  int                  err_total   = 0;
  int                  cmp_count   = 0;
  int                  cyc         = 0;
  assign base = {cfg.base_addr_high_cfg, cfg.base_addr_low_cfg};
  always #2 clk_sys = ~clk_sys;
  hwa_alarm_top #(.LO_HALF_CYC(LO), .HI_HALF_CYC(HI), .PHASE_CYC(PH)) dut (
    .clk_sys(clk_sys), .resetn(resetn), .io_req(io_req), .cfg(cfg), .io_rdata(io_rdata),
    .temp(temp), .volt_alarm(volt_alarm), .fan_alarm(fan_alarm), .case_open_n(case_open_n),
    .alarm_pin_n(alarm_pin_n), .tone_alarm_out(tone_alarm_out), .tone_alarm_oe(tone_alarm_oe));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    // a note left unanswered means a read never came back
    if (exp_q.size() != 0)
      err_total++;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wt(input int k);
    repeat (k) @(posedge clk_sys) #1;
  endtask
  // one host cycle; strobes stay up so accesses can run back to back
  task automatic io(input logic [15:0] a, input logic w, input logic r, input logic [7:0] d);
    io_req.addr  = a;
    io_req.wdata = d;
    io_req.wr    = w;
    io_req.rd    = r;
    wt(1);
  endtask
  task automatic idle();
    io_req.wr = 1'b0;
    io_req.rd = 1'b0;
    wt(1);
  endtask
  task automatic ridx(input logic [7:0] e);
    exp_q.push_back(e);
    io(base + IDX_PORT_OFS, 1'b0, 1'b1, 8'h00);
  endtask
  task automatic wreg(input logic [6:0] i, input logic [7:0] v);
    io(base + IDX_PORT_OFS, 1'b1, 1'b0, {1'b0, i});
    io(base + DATA_PORT_OFS, 1'b1, 1'b0, v);
    idle();
  endtask
  task automatic rreg(input logic [6:0] i, input logic [7:0] e);
    io(base + IDX_PORT_OFS, 1'b1, 1'b0, {1'b0, i});
    exp_q.push_back(e);
    io(base + DATA_PORT_OFS, 1'b0, 1'b1, 8'h00);
    idle();
  endtask
  task automatic strobe(input int s, input logic [7:0] v);
    temp.valid[s] = 1'b1;
    temp.value[s] = v;
    wt(1);
    temp.valid = '0;
    wt(1);
  endtask
  // cycles until the tone pin enable moves, capped at lim
  task automatic measure(input int lim, output logic [7:0] cnt);
    logic prev;
    prev = tone_alarm_oe;
    cnt  = 8'h00;
    while (tone_alarm_oe === prev && cnt < 8'(lim)) begin
      wt(1);
      cnt++;
    end
  endtask
  // read data monitor: answer checked just after the edge that took the read, once settled
  always @(posedge clk_sys) begin
    took_q <= resetn && io_req.rd && (io_req.addr == base + IDX_PORT_OFS || io_req.addr == base + DATA_PORT_OFS);
    #1;
    if (took_q && exp_q.size() > 0)
      chk8(io_rdata, exp_q.pop_front());
  end
  // hang guard, far above the expected run length
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    cfg = '{8'h02, 8'h90, 8'h40, 8'h00, 8'h00};
    repeat (3) @(posedge clk_sys);
    #1 resetn = 1'b1;
    wt(1);
    chk1(tone_alarm_oe, 1'b1);
    chk1(alarm_pin_n, 1'b1);
    ridx(8'h00);
    ridx(8'h00);
    io(base + IDX_PORT_OFS, 1'b1, 1'b0, 8'hff);
    ridx(8'h7f);
    idle();
    rreg(IDX_LIM_OVER, LIM_OVER_RST);
    rreg(IDX_LIM_HYST, LIM_HYST_RST);
    // limits are banked per sensor; aux hysteresis sits between the later aux readings 4c and 40
    wreg(IDX_BANK, 8'h02);
    wreg(IDX_LIM_HYST, 8'h48);
    rreg(IDX_LIM_HYST, 8'h48);
    rreg(IDX_LIM_OVER, LIM_OVER_RST);
    wreg(IDX_BANK, 8'h00);
    rreg(IDX_LIM_HYST, LIM_HYST_RST);
    rreg(IDX_STATUS, 8'h00);
    io(base + 16'h0007, 1'b1, 1'b0, 8'h33);
    io(base + 16'h0004, 1'b0, 1'b1, 8'h00);
    ridx({1'b0, IDX_STATUS});
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      io(base + IDX_PORT_OFS, 1'b1, 1'b0, seed[7:0]);
      ridx({1'b0, seed[6:0]});
    end
    idle();
    $display("test ports done");
    // management pin, two-times mode on the cpu sensor
    strobe(1, 8'h60);
    chk1(alarm_pin_n, 1'b0);
    strobe(1, 8'h60);
    rreg(IDX_STATUS, 8'h01);
    chk1(alarm_pin_n, 1'b1);
    strobe(1, 8'h70);
    chk1(alarm_pin_n, 1'b1);
    strobe(1, 8'h40);
    chk1(alarm_pin_n, 1'b0);
    rreg(IDX_STATUS, 8'h01);
    chk1(alarm_pin_n, 1'b1);
    $display("test two_times done");
    // comparator mode on the aux sensor
    wreg(IDX_TEMP_MODE, 8'h40);
    strobe(2, 8'h60);
    chk1(alarm_pin_n, 1'b0);
    rreg(IDX_STATUS, 8'h02);
    chk1(alarm_pin_n, 1'b1);
    strobe(2, 8'h4c);
    chk1(alarm_pin_n, 1'b0);
    strobe(2, 8'h40);
    rreg(IDX_STATUS, 8'h02);
    strobe(2, 8'h40);
    chk1(alarm_pin_n, 1'b1);
    $display("test comparator done");
    // over-temp function, comparator
    cfg.alarm_pin_function_cfg = 8'h00;
    wreg(IDX_OVT_CFG, 8'h40);
    strobe(0, 8'h60);
    chk1(alarm_pin_n, 1'b0);
    strobe(0, 8'h4c);
    chk1(alarm_pin_n, 1'b0);
    strobe(0, 8'h40);
    chk1(alarm_pin_n, 1'b1);
    strobe(1, 8'h60);
    chk1(alarm_pin_n, 1'b1);
    strobe(1, 8'h40);
    wreg(IDX_TEMP_MODE, 8'h00);
    rreg(IDX_STATUS, 8'h01);
    // over-temp function, event mode in all three select bits
    wreg(IDX_OVT_CFG, 8'h50);
    for (int b = 1; b < 3; b++) begin
      wreg(IDX_BANK, 8'(b));
      wreg(IDX_OVT_MODE, 8'h02);
    end
    wreg(IDX_BANK, 8'h00);
    strobe(0, 8'h60);
    chk1(alarm_pin_n, 1'b0);
    strobe(0, 8'h60);
    chk1(alarm_pin_n, 1'b0);
    rreg(IDX_STATUS, 8'h04);
    chk1(alarm_pin_n, 1'b1);
    strobe(0, 8'h70);
    chk1(alarm_pin_n, 1'b1);
    strobe(0, 8'h40);
    chk1(alarm_pin_n, 1'b0);
    rreg(IDX_STATUS, 8'h04);
    chk1(alarm_pin_n, 1'b1);
    $display("test over_temp done");
    // intrusion latch and both clear paths
    case_open_n = 1'b0;
    wt(6);
    rreg(IDX_INTRUSION, 8'h40);
    case_open_n = 1'b1;
    wt(6);
    rreg(IDX_INTRUSION, 8'h60);
    wreg(IDX_INTRUSION, 8'h80);
    wreg(IDX_INTRUSION, 8'h00);
    rreg(IDX_INTRUSION, 8'h20);
    case_open_n = 1'b0;
    wt(6);
    case_open_n = 1'b1;
    wt(6);
    cfg.intrusion_clear_cfg = 8'h20;
    wt(2);
    cfg.intrusion_clear_cfg = 8'h00;
    wt(3);
    rreg(IDX_INTRUSION, 8'h20);
    $display("test intrusion done");
    // tone: user bit, then a voltage event
    wreg(IDX_BANK, 8'h04);
    wreg(IDX_USER_TONE, 8'h20);
    measure(30, n);
    chk8(n, 8'd30);
    wreg(IDX_BANK, 8'h00);
    wreg(IDX_TONE_EN1, 8'h80);
    measure(50, n);
    measure(50, n);
    chk8(n, 8'(LO));
    wt(PH);
    measure(50, n);
    measure(50, n);
    chk8(n, 8'(HI));
    wreg(IDX_BANK, 8'h04);
    wreg(IDX_USER_TONE, 8'h00);
    wt(3);
    chk1(tone_alarm_oe, 1'b1);
    wreg(IDX_BANK, 8'h00);
    wreg(IDX_TONE_EN0, 8'h01);
    volt_alarm = 9'h002;
    fan_alarm  = 5'h01;
    measure(30, n);
    chk8(n, 8'd30);
    volt_alarm = 9'h001;
    measure(50, n);
    measure(50, n);
    chk8(n, 8'(LO));
    volt_alarm = '0;
    fan_alarm  = '0;
    wt(4);
    chk1(tone_alarm_oe, 1'b1);
    cfg.tone_pin_function_cfg = 8'h02;
    wt(3);
    chk1(tone_alarm_oe, 1'b0);
    $display("test tone done");
    summarize();
  end
endmodule

bind hwa_alarm_top hwa_alarm_props #(.LO_HALF_CYC(LO_HALF_CYC), .HI_HALF_CYC(HI_HALF_CYC), .PHASE_CYC(PHASE_CYC))
  u_props (.clk_sys(clk_sys), .resetn(resetn), .io_req(io_req), .cfg(cfg), .io_rdata(io_rdata),
    .temp(temp), .volt_alarm(volt_alarm), .fan_alarm(fan_alarm), .case_open_n(case_open_n),
    .alarm_pin_n(alarm_pin_n), .tone_alarm_out(tone_alarm_out), .tone_alarm_oe(tone_alarm_oe));
